// ### core/cmp_ctrl_pkg.sv
// Purpose: constants and types for the comparator output control block
// Assumes: avalon-mm register slave, 32-bit words, byte addresses
// Notes: one control word per comparator plus shared mirror and flags
package cmp_ctrl_pkg;
   localparam int num_cmp = 3;
   localparam logic [5:0] addr_mirror = 6'h00;
   localparam logic [5:0] addr_flags = 6'h04;
   localparam logic [5:0] addr_ctrl_base = 6'h10;
   localparam logic [5:0] addr_ctrl_step = 6'h04;
   // control word fields
   localparam int bit_on = 0;
   localparam int bit_pol = 1;
   localparam int bit_hys = 2;
   localparam int bit_sync = 3;
   localparam int bit_rise = 4;
   localparam int bit_fall = 5;
   localparam int bit_ie = 6;
   localparam int pch_lo = 8;
   localparam int nch_lo = 12;
   localparam logic [31:0] ctrl_mask = 32'h0000_777f;
   localparam logic [31:0] ctrl_reset = 32'h0000_0000;
   localparam logic [31:0] unmapped_value = 32'h0000_0000;
   // positive select codes
   localparam logic [2:0] pch_pin0 = 3'h0;
   localparam logic [2:0] pch_pin1 = 3'h1;
   localparam logic [2:0] pch_dac = 3'h5;
   localparam logic [2:0] pch_fvr = 3'h6;
   localparam logic [2:0] pch_gnd = 3'h7;
   // negative select codes: 0..4 pins, 6 reference, 7 ground
   localparam logic [2:0] nch_pin_max = 3'h4;
   localparam logic [2:0] nch_fvr = 3'h6;
   localparam logic [2:0] nch_gnd = 3'h7;

   typedef struct packed {
      logic [7:0] pos_sel; // one-hot: pin0,pin1,dac,fvr,gnd,-,-,-
      logic [7:0] neg_sel; // one-hot: pin0..pin4,fvr,gnd,-
      logic hys_on;
   } analog_ctl_t;
endpackage

// ### core/comparator_output_control.sv
// Purpose: digital control around three analog comparators
// Assumes: timer clock input sampled on mclk_i, synchronous to it
// Notes: analog select lines are one-hot and all low while a comparator is off
//
// Overview of operation
// RULE_01 - mirror register shows outputs in bits 2..0
// RULE_02 - hysteresis applied only while its enable set
// RULE_03 - sync bit latches output to timer clock
// RULE_04 - latch captures on timer clock falling edge
// RULE_05 - latch uses post-prescaler timer clock
// RULE_06 - timer counts rising, latch updates falling
// RULE_07 - outputs offered as timer gate sources
// RULE_08 - software should enable sync for timer gating
// RULE_09 - separate rising and falling detectors per comparator
// RULE_10 - flag set by enabled rising or falling edge
// RULE_11 - request needs on, polarity, enables, global enables
// RULE_12 - software alone clears the interrupt flag
// RULE_13 - set wins over simultaneous software clear
// RULE_14 - polarity or enable toggling may set flag
// RULE_15 - positive select routes pin, dac, reference, ground
// RULE_16 - comparator off disconnects all its inputs
// RULE_17 - negative select routes five pins, reference, ground
// RULE_18 - software sets analog select and direction first
// RULE_19 - positive codes 001 pin1, 101 dac, 110 ref, 111 gnd
// RULE_20 - polarity bit inverts raw compare result
// RULE_21 - edges found against previous cycle's output
//
// The Avalon-MM slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module comparator_output_control (
   input wire logic mclk_i,
   input wire logic srst_i,
   input wire logic clk_en_i,
   input wire logic [5:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic [2:0] raw_compare_i,
   input wire logic timer_clk_i,
   input wire logic peripheral_irq_enable_i,
   input wire logic global_irq_enable_i,
   output cmp_ctrl_pkg::analog_ctl_t analog_ctl_o [3],
   output logic [2:0] gate_source_o,
   output logic [2:0] comparator_irq_flag_o,
   output logic [2:0] irq_request_o,
   output logic irq_o
);
   import cmp_ctrl_pkg::*;

   logic [31:0] ctrl [num_cmp];
   logic [2:0] flag;
   logic [2:0] latched;
   logic [2:0] result;
   logic [2:0] prev_result;
   logic [2:0] rise_hit;
   logic [2:0] fall_hit;
   logic tclk_prev;
   logic tclk_fall;
   logic ack;
   logic [31:0] next_rdata;
   logic [2:0] flag_clear;
   logic [31:0] be_mask;

   // index of the control word addressed, or num_cmp when none
   function automatic int ctrl_index(input logic [5:0] a);
      int r;
      r = num_cmp;
      for (int i = 0; i < num_cmp; i++) begin
         if (a == 6'(addr_ctrl_base + 6'(i) * addr_ctrl_step)) begin
            r = i;
         end
      end
      return r;
   endfunction

   // expand byte enables to a bit mask
   function automatic logic [31:0] lane_mask(input logic [3:0] be);
      logic [31:0] m;
      m = 32'h0000_0000;
      for (int i = 0; i < 4; i++) begin
         m[i*8 +: 8] = {8{be[i]}};
      end
      return m;
   endfunction

   // one wait state: waitrequest is low during the second cycle of a request
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         ack <= 1'b0;
      end else if (clk_en_i) begin
         ack <= (avs_read_i || avs_write_i) && !ack;
      end
   end
   assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack;

   assign be_mask = lane_mask(avs_byteenable_i);

   // control words
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         for (int i = 0; i < num_cmp; i++) begin
            ctrl[i] <= ctrl_reset;
         end
      end else if (clk_en_i && avs_write_i && ack) begin
         for (int i = 0; i < num_cmp; i++) begin
            if (ctrl_index(avs_address_i) == i) begin
               ctrl[i] <= ((ctrl[i] & ~be_mask) |
                  (avs_writedata_i & be_mask)) & ctrl_mask;
            end
         end
      end
   end

   // write one to clear a flag in the flag register
   always_comb begin
      flag_clear = 3'h0;
      if (avs_write_i && ack && avs_address_i == addr_flags &&
          avs_byteenable_i[0]) begin
         flag_clear = avs_writedata_i[2:0];
      end
   end

   // read data
   always_comb begin
      next_rdata = unmapped_value;
      if (avs_address_i == addr_mirror) begin
         next_rdata = {29'h0, result}; // RULE_01
      end else if (avs_address_i == addr_flags) begin
         next_rdata = {29'h0, flag};
      end else if (ctrl_index(avs_address_i) < num_cmp) begin
         for (int i = 0; i < num_cmp; i++) begin
            if (ctrl_index(avs_address_i) == i) begin
               next_rdata = ctrl[i];
            end
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         avs_readdata_o <= 32'h0000_0000;
      end else if (clk_en_i && avs_read_i && !ack) begin
         avs_readdata_o <= next_rdata;
      end
   end

   // timer clock falling edge; timer counts on the rising edge,
   // so a latched change never lands on a count
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         tclk_prev <= 1'b0;
      end else if (clk_en_i) begin
         tclk_prev <= timer_clk_i;
      end
   end
   assign tclk_fall = tclk_prev && !timer_clk_i; // RULE_04 RULE_05 RULE_06

   // polarity applied before the latch, so the latch holds the output
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         latched <= 3'h0;
      end else if (clk_en_i && tclk_fall) begin
         for (int i = 0; i < num_cmp; i++) begin
            latched[i] <= (raw_compare_i[i] & ctrl[i][bit_on]) ^
               ctrl[i][bit_pol]; // RULE_04
         end
      end
   end

   // off comparator reads as zero before polarity, so toggling on or
   // polarity moves the output even while off
   always_comb begin
      for (int i = 0; i < num_cmp; i++) begin
         if (ctrl[i][bit_sync]) begin
            result[i] = latched[i]; // RULE_03
         end else begin
            result[i] = (raw_compare_i[i] & ctrl[i][bit_on]) ^
               ctrl[i][bit_pol]; // RULE_20 RULE_14
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         prev_result <= 3'h0;
         gate_source_o <= 3'h0;
      end else if (clk_en_i) begin
         prev_result <= result; // RULE_21
         gate_source_o <= result; // RULE_07
      end
   end

   assign rise_hit = result & ~prev_result; // RULE_09
   assign fall_hit = ~result & prev_result; // RULE_09

   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         flag <= 3'h0;
      end else if (clk_en_i) begin
         for (int i = 0; i < num_cmp; i++) begin
            if ((rise_hit[i] && ctrl[i][bit_rise]) ||
                (fall_hit[i] && ctrl[i][bit_fall])) begin
               flag[i] <= 1'b1; // RULE_10 RULE_13
            end else if (flag_clear[i]) begin
               flag[i] <= 1'b0; // RULE_12
            end
         end
      end
   end
   assign comparator_irq_flag_o = flag;

   always_comb begin
      for (int i = 0; i < num_cmp; i++) begin
         irq_request_o[i] = flag[i] && ctrl[i][bit_ie] && ctrl[i][bit_on] &&
            ctrl[i][bit_pol] && (ctrl[i][bit_rise] || ctrl[i][bit_fall]) &&
            peripheral_irq_enable_i && global_irq_enable_i; // RULE_11
      end
   end
   assign irq_o = |irq_request_o;

   // analog steering
   always_comb begin
      for (int i = 0; i < num_cmp; i++) begin
         logic [2:0] p;
         logic [2:0] n;
         p = ctrl[i][pch_lo +: 3];
         n = ctrl[i][nch_lo +: 3];
         analog_ctl_o[i].pos_sel = 8'h00;
         analog_ctl_o[i].neg_sel = 8'h00;
         analog_ctl_o[i].hys_on = ctrl[i][bit_hys] && ctrl[i][bit_on]; // RULE_02
         if (ctrl[i][bit_on]) begin // RULE_16
            if (p == pch_pin0) begin
               analog_ctl_o[i].pos_sel = 8'h01; // RULE_15
            end else if (p == pch_pin1) begin
               analog_ctl_o[i].pos_sel = 8'h02; // RULE_19
            end else if (p == pch_dac) begin
               analog_ctl_o[i].pos_sel = 8'h04; // RULE_19
            end else if (p == pch_fvr) begin
               analog_ctl_o[i].pos_sel = 8'h08; // RULE_19
            end else if (p == pch_gnd) begin
               analog_ctl_o[i].pos_sel = 8'h10; // RULE_19
            end
            if (n <= nch_pin_max) begin
               analog_ctl_o[i].neg_sel = 8'(8'h01 << n); // RULE_17
            end else if (n == nch_fvr) begin
               analog_ctl_o[i].neg_sel = 8'h20; // RULE_17
            end else if (n == nch_gnd) begin
               analog_ctl_o[i].neg_sel = 8'h40; // RULE_17
            end
         end
      end
   end

   // assertions
   a_mirror_bits: assert property (@(posedge mclk_i) disable iff (srst_i)
      clk_en_i && avs_read_i && !ack && avs_address_i == addr_mirror |=>
      avs_readdata_o == {29'h0, $past(result)}) // RULE_01
      else $error("mirror read mismatch");
   a_flag_set_wins: assert property (@(posedge mclk_i) disable iff (srst_i)
      clk_en_i && rise_hit[0] && ctrl[0][bit_rise] |=> flag[0]) // RULE_13
      else $error("rising edge lost");
   a_fall_set: assert property (@(posedge mclk_i) disable iff (srst_i)
      clk_en_i && fall_hit[1] && ctrl[1][bit_fall] |=> flag[1]) // RULE_10
      else $error("falling edge lost");
   a_flag_sticky: assert property (@(posedge mclk_i) disable iff (srst_i)
      flag[2] && !flag_clear[2] |=> flag[2]) // RULE_12
      else $error("flag dropped without clear");
   a_off_disconnect: assert property (@(posedge mclk_i) disable iff (srst_i)
      !ctrl[0][bit_on] |-> analog_ctl_o[0].pos_sel == 8'h00 &&
      analog_ctl_o[0].neg_sel == 8'h00) // RULE_16
      else $error("inputs routed while off");
   a_hys_gate: assert property (@(posedge mclk_i) disable iff (srst_i)
      analog_ctl_o[1].hys_on |-> ctrl[1][bit_hys]) // RULE_02
      else $error("hysteresis without enable");
   a_sync_hold: assert property (@(posedge mclk_i) disable iff (srst_i)
      ctrl[0][bit_sync] && !tclk_fall && $stable(ctrl[0]) |=>
      $stable(latched[0])) // RULE_04
      else $error("latch moved off falling edge");
   a_irq_gate: assert property (@(posedge mclk_i) disable iff (srst_i)
      irq_o |-> peripheral_irq_enable_i && global_irq_enable_i) // RULE_11
      else $error("irq without global enables");
   a_gate_follow: assert property (@(posedge mclk_i) disable iff (srst_i)
      clk_en_i |=> gate_source_o == $past(result)) // RULE_07
      else $error("gate source stale");
   a_wait_once: assert property (@(posedge mclk_i) disable iff (srst_i)
      avs_read_i && !ack && clk_en_i |=> !avs_waitrequest_o)
      else $error("slave did not answer");

   a_pass_plain: assert property (@(posedge mclk_i) // RULE_20
      disable iff (srst_i) ctrl[0][bit_on] && !ctrl[0][bit_sync] &&
      !ctrl[0][bit_pol] |-> result[0] == raw_compare_i[0])
      else $error("output not following compare");
   a_pass_invert: assert property (@(posedge mclk_i) // RULE_20
      disable iff (srst_i) ctrl[0][bit_on] && !ctrl[0][bit_sync] &&
      ctrl[0][bit_pol] |-> result[0] != raw_compare_i[0])
      else $error("polarity not inverting");
   a_latch_take: assert property (@(posedge mclk_i) // RULE_04
      disable iff (srst_i) clk_en_i && tclk_fall && ctrl[1][bit_on] &&
      !ctrl[1][bit_pol] |=> latched[1] == $past(raw_compare_i[1]))
      else $error("latch missed falling edge");
   a_tclk_fall: assert property (@(posedge mclk_i) // RULE_05
      disable iff (srst_i) $past(clk_en_i) && tclk_fall |->
      $past(timer_clk_i) && !timer_clk_i)
      else $error("false timer clock edge");
   a_sync_select: assert property (@(posedge mclk_i) // RULE_03
      disable iff (srst_i) ctrl[2][bit_sync] |-> result[2] == latched[2])
      else $error("sync output not latched");
   a_rise_flag: assert property (@(posedge mclk_i) // RULE_10
      disable iff (srst_i) clk_en_i && rise_hit[1] && ctrl[1][bit_rise]
      |=> flag[1])
      else $error("rising edge lost");
   a_fall_flag: assert property (@(posedge mclk_i) // RULE_10
      disable iff (srst_i) clk_en_i && fall_hit[2] && ctrl[2][bit_fall]
      |=> flag[2])
      else $error("falling edge lost");
   a_no_spurious: assert property (@(posedge mclk_i) // RULE_10
      disable iff (srst_i) clk_en_i && !flag[0] && !rise_hit[0] &&
      !fall_hit[0] |=> !flag[0])
      else $error("flag set without edge");
   a_clear_works: assert property (@(posedge mclk_i) // RULE_12
      disable iff (srst_i) clk_en_i && flag_clear[1] && !rise_hit[1] &&
      !fall_hit[1] |=> !flag[1])
      else $error("flag clear ignored");
   a_prev_track: assert property (@(posedge mclk_i) // RULE_21
      disable iff (srst_i) clk_en_i |=> prev_result == $past(result))
      else $error("previous output stale");
   a_pos_ground: assert property (@(posedge mclk_i) // RULE_19
      disable iff (srst_i) ctrl[0][bit_on] && ctrl[0][pch_lo +: 3] ==
      pch_gnd |-> analog_ctl_o[0].pos_sel == 8'h10)
      else $error("positive ground not routed");
   a_neg_ground: assert property (@(posedge mclk_i) // RULE_17
      disable iff (srst_i) ctrl[0][bit_on] && ctrl[0][nch_lo +: 3] ==
      nch_gnd |-> analog_ctl_o[0].neg_sel == 8'h40)
      else $error("negative ground not routed");
   a_cen_freeze: assert property (@(posedge mclk_i) disable iff (srst_i)
      !clk_en_i |=> $stable(flag) && $stable(gate_source_o) &&
      $stable(latched))
      else $error("state moved while frozen");

   c_rise_flag: cover property (@(posedge mclk_i) rise_hit[0] ##1 flag[0]);
   c_cen_freeze: cover property (@(posedge mclk_i) !clk_en_i ##1 clk_en_i);
   c_clear_race: cover property (@(posedge mclk_i)
      flag_clear[0] && rise_hit[0] && ctrl[0][bit_rise]);
   c_sync_latch: cover property (@(posedge mclk_i)
      ctrl[1][bit_sync] && tclk_fall);
   c_irq: cover property (@(posedge mclk_i) irq_o);
endmodule
`default_nettype wire

// ### dv/cmp_far_model.sv
// Purpose: far-side model, comparator cores and first timer clock
// Assumes: timer clock is mclk divided by 4, after the prescaler
// Notes: a disconnected positive input gives a result that changes every cycle
`timescale 1ns/1ps
`default_nettype none
module cmp_far_model (
   input wire logic mclk_i,
   input wire logic run_i,
   input wire logic [2:0] level_i,
   input wire cmp_ctrl_pkg::analog_ctl_t ctl_i [3],
   output logic [2:0] raw_o,
   output logic tclk_o
);
   import cmp_ctrl_pkg::*;
   logic [1:0] div = 2'h0;
   logic wob = 1'b0;
   // clock stands still unless the bench runs the timer
   always @(posedge mclk_i) begin
      wob <= ~wob;
      if (run_i) div <= div + 2'h1;
   end
   assign tclk_o = div[1];
   // pins are analog inputs with their output drivers off
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         raw_o[i] = (ctl_i[i].pos_sel != 8'h00) ? level_i[i] : wob;
      end
   end
endmodule
`default_nettype wire

// ### dv/tb_comparator_output_control.sv
// Purpose: self-checking bench for the comparator output control
// Assumes: one wait state per bus access, result follows raw at once
// Notes: reads are checked by a monitor against a queue of notes
`timescale 1ns/1ps
`default_nettype none
module tb_comparator_output_control;
   import cmp_ctrl_pkg::*;
   logic mclk_i = 1'b0;
   logic srst_i, rd_en, wr_en, run, pie, global_irq_enable, wreq, tclk;
   logic [5:0] adr;
   logic [31:0] wd, rdat;
   logic [3:0] be;
   logic [2:0] lvl, polarity_select, raw, gate, flg, irqr;
   logic irq, cen;
   analog_ctl_t ctl [3];
   logic [31:0] q [$];
   int bad_count = 0;
   int tests_run = 0;
   int seed = 30547;
   logic [7:0] pexp [8] = '{8'h01, 8'h02, 8'h00, 8'h00, 8'h00, 8'h04,
      8'h08, 8'h10};
   logic [7:0] nexp [8] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h00,
      8'h20, 8'h40};
   always #2.5 mclk_i = ~mclk_i;
   comparator_output_control u_dut (.mclk_i(mclk_i), .srst_i(srst_i),
      .clk_en_i(cen), .avs_address_i(adr), .avs_read_i(rd_en),
      .avs_write_i(wr_en), .avs_writedata_i(wd), .avs_byteenable_i(be),
      .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .raw_compare_i(raw),
      .timer_clk_i(tclk), .peripheral_irq_enable_i(pie),
      .global_irq_enable_i(global_irq_enable), .analog_ctl_o(ctl), .gate_source_o(gate),
      .comparator_irq_flag_o(flg), .irq_request_o(irqr), .irq_o(irq));
   cmp_far_model u_far (.mclk_i(mclk_i), .run_i(run), .level_i(lvl),
      .ctl_i(ctl), .raw_o(raw), .tclk_o(tclk));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      adr <= a;
      rd_en <= ~w;
      wr_en <= w;
      wd <= d;
      do @(posedge mclk_i); while (wreq !== 1'b0);
      rd_en <= 1'b0;
      wr_en <= 1'b0;
      @(posedge mclk_i);
   endtask
   task automatic rd(input logic [5:0] a, input logic [31:0] e);
      q.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask
   task automatic wc(input int i, input logic [31:0] v);
      bus(1'b1, addr_ctrl_base + addr_ctrl_step * 6'(i), v);
   endtask
   // read data is taken at the edge where the wait ends
   always @(posedge mclk_i) begin
      if (rd_en && wreq === 1'b0) chk(rdat, q.pop_front());
   end
   task automatic close_out;
      $display("counts: run=%0d bad=%0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge mclk_i);
      bad_count++;
      close_out();
   end
   initial begin
      srst_i = 1'b1; rd_en = 1'b0; wr_en = 1'b0; adr = 6'h00; wd = 32'h0;
      be = 4'hf; lvl = 3'h0; run = 1'b0; pie = 1'b0; global_irq_enable = 1'b0;
      cen = 1'b1;
      repeat (8) @(posedge mclk_i);
      srst_i <= 1'b0;
      rd(addr_mirror, 32'h0);
      rd(addr_flags, 32'h0);
      rd(addr_ctrl_base, ctrl_reset);
      bus(1'b1, 6'h3c, 32'hffff_ffff);
      rd(6'h3c, unmapped_value);
      wc(2, 32'hffff_ffff);
      rd(addr_ctrl_base + 6'h08, ctrl_mask);
      $display("done: registers");
      for (int c = 0; c < 8; c++) begin
         wc(0, (32'(c) << pch_lo) | (32'(c) << nch_lo) | 32'h5);
         chk(32'(ctl[0].pos_sel), 32'(pexp[c]));
         chk(32'(ctl[0].neg_sel), 32'(nexp[c]));
         chk(32'(ctl[0].hys_on), 32'h1);
         wc(0, (32'(c) << pch_lo) | (32'(c) << nch_lo));
         chk(32'({ctl[0].pos_sel, ctl[0].neg_sel}), 32'h0);
         chk(32'(ctl[0].hys_on), 32'h0);
      end
      $display("done: input select");
      for (int k = 0; k < 6; k++) begin
         polarity_select = 3'($random(seed));
         for (int i = 0; i < 3; i++) wc(i, 32'h1 | (32'(polarity_select[i]) << bit_pol));
         lvl <= 3'($random(seed));
         repeat (3) @(posedge mclk_i);
         rd(addr_mirror, 32'(lvl ^ polarity_select));
         chk(32'(gate), 32'(lvl ^ polarity_select));
      end
      $display("done: polarity");
      lvl <= 3'h7;
      wc(0, 32'h53);
      wc(1, 32'h21);
      wc(2, 32'h01);
      bus(1'b1, addr_flags, 32'h7);
      lvl <= 3'h0;
      repeat (2) @(posedge mclk_i);
      rd(addr_flags, 32'h3);
      chk(32'(irq), 32'h0);
      pie <= 1'b1;
      @(posedge mclk_i);
      chk(32'(irq), 32'h0);
      global_irq_enable <= 1'b1;
      @(posedge mclk_i);
      chk(32'({irqr, irq}), 32'h3);
      bus(1'b1, addr_flags, 32'h1);
      rd(addr_flags, 32'h2);
      lvl <= 3'h7;
      repeat (2) @(posedge mclk_i);
      fork
         bus(1'b1, addr_flags, 32'h7);
         begin
            @(posedge mclk_i);
            lvl <= 3'h0;
         end
      join
      rd(addr_flags, 32'h3);
      $display("done: edge flags");
      wc(2, 32'h30);
      bus(1'b1, addr_flags, 32'h7);
      wc(2, 32'h32);
      rd(addr_flags, 32'h4);
      $display("done: toggle while off");
      // sync is used whenever the output gates the timer
      wc(0, 32'h9);
      run <= 1'b1;
      repeat (2) @(posedge mclk_i);
      run <= 1'b0;
      lvl <= 3'h1;
      repeat (4) @(posedge mclk_i);
      rd(addr_mirror, 32'h4);
      run <= 1'b1;
      repeat (2) @(posedge mclk_i);
      run <= 1'b0;
      repeat (4) @(posedge mclk_i);
      rd(addr_mirror, 32'h5);
      chk(32'(gate), 32'h5);
      $display("done: sync latch");
      cen <= 1'b0;
      lvl <= 3'h2;
      repeat (2) @(posedge mclk_i);
      chk(32'(gate), 32'h5);
      cen <= 1'b1;
      repeat (3) @(posedge mclk_i);
      chk(32'(gate), 32'h7);
      $display("done: clock enable");
      repeat (3) @(posedge mclk_i);
      close_out();
   end
endmodule
`default_nettype wire
